//--- hw/airm_pkg.sv
// Purpose: Shared constants for the analog input range monitor
// Assumes: 8 channels, 16-bit signed conversion results
// Notes:   Byte addresses on a 32-bit classic Wishbone slave
package airm_pkg;
	localparam int          NCH        = 8;
	localparam int          SW         = 23;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_STAT   = 8'h04;
	localparam logic [7:0]  OFS_IRQS   = 8'h08;
	localparam logic [7:0]  OFS_IRQM   = 8'h0c;
	localparam logic [7:0]  OFS_CAL    = 8'h10;
	localparam logic [7:0]  OFS_SUBST  = 8'h14;
	localparam logic [7:0]  OFS_FLAGS  = 8'h18;
	localparam logic [2:0]  BLK_VALUE  = 3'h2;
	localparam logic [2:0]  BLK_PRESET = 3'h3;
	localparam logic [2:0]  BLK_DELTA  = 3'h4;
	// Control field positions and failure interrupt bit
	localparam int          CT_REJ60   = 0;
	localparam int          CT_SMOOTH  = 1;
	localparam int          CT_RANGE   = 4;
	localparam int          CT_FREEZE  = 6;
	localparam int          CT_SLEEP   = 7;
	localparam int          CT_TEST    = 8;
	localparam int          CT_TREJ60  = 9;
	localparam int          CT_TSMOOTH = 10;
	localparam int          IRQ_FAIL   = 8;
	// Reset values: 50 Hz, 32 samples, bipolar
	localparam logic [12:0] CTRL_RST   = 13'h0008;
	localparam logic [7:0]  CAL_RST    = 8'hff;
	localparam logic [15:0] SUBST_RST  = 16'h00ff;
	// Range codes
	typedef enum logic [1:0] {
		RNG_BIP,
		RNG_OFS4,
		RNG_UNI0,
		RNG_OFS1
	} airm_range_e;
	// Limits in scaled counts
	localparam logic signed [15:0] LIM_HI      = 16'sh7e00;
	localparam logic signed [15:0] LIM_LO_BIP  = 16'sh8200;
	localparam logic signed [15:0] LIM_LO_OFS  = 16'sh1800;
	localparam logic signed [15:0] LIM_LO_UNI0 = 16'shff00;
	// Sample periods
	localparam int          CLK_NS     = 40;
	localparam int          T50_NS     = 10_000_000;
	localparam int          T60_NS     = 8_330_000;
	localparam int          T50_CYC    = T50_NS / CLK_NS;
	localparam int          T60_CYC    = T60_NS / CLK_NS;
	localparam int          TW         = 18;
endpackage : airm_pkg

//--- hw/airm_top.sv
// Purpose: Range monitor, scaling, smoothing and substitution for 8 analog inputs
// Assumes: Converter returns one result per conv_start per channel, in any order
// Notes:   Registers on classic Wishbone, ack one cycle after the request
// How it works
// RULE_01: Below-range flag under range's lower limit
// RULE_02: Above-range flag when value exceeds 32256
// RULE_03: Uncalibrated channel lights both flags
// RULE_04: Scale full scale to plus/minus 32000
// RULE_05: Freeze presents held or preset values
// RULE_06: Failure: error light, event, readable status
// RULE_07: Sample every 10 ms or 8.33 ms
// RULE_08: Module-wide running average, 2 to 128
// RULE_09: Limits follow the module range selection
// RULE_10: Test filter overrides, config restored after
// RULE_11: Per-input force of preset value
// RULE_12: Change flag when delta exceeded, zero disables
// RULE_13: Sleep stops conversion, presents preset values
// RULE_14: Flags refresh once per sample per channel
// RULE_15: Restart average on smoothing or range change
`timescale 1ns/1ps
module airm_top #(
	parameter int T50 = airm_pkg::T50_CYC,
	parameter int T60 = airm_pkg::T60_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        adc_valid,
	input  wire logic [2:0]  adc_chan,
	input  wire logic [15:0] adc_data,
	input  wire logic        fail_in,
	output logic             conv_start,
	output logic      [7:0]  below_range_flag,
	output logic      [7:0]  above_range_flag,
	output logic             err_led,
	output logic             fail_evt,
	output logic             irq
);
	localparam int N = airm_pkg::NCH;
	localparam int S = airm_pkg::SW;

	logic        [12:0]    ctrl_r;
	logic        [7:0]     cal_r;
	logic        [7:0]     hold_last_sample;
	logic        [7:0]     force_r;
	logic        [8:0]     irqs_r;
	logic        [8:0]     irqm_r;
	logic signed [15:0]    preset_substitute_value [N];
	logic        [15:0]    change_detect_delta [N];
	logic signed [S-1:0]   sum_r  [N];
	logic signed [15:0]    live_r [N];
	logic signed [15:0]    last_r [N];
	logic signed [15:0]    rep_r  [N];
	logic        [7:0]     below_r;
	logic        [7:0]     above_r;
	logic        [7:0]     restart_r;
	logic        [airm_pkg::TW-1:0] tick_cnt_r;
	logic                  fail_d_r;
	logic                  ack_r;
	logic        [31:0]    dat_r;

	// Bus decode, a write lands on the edge that samples ack high
	logic        req;
	logic        wr;
	logic [2:0]  blk;
	logic [2:0]  widx;
	assign req  = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign blk  = wb_adr_i[7:5];
	assign widx = wb_adr_i[4:2];

	// Effective filter setup, test values win while test is on
	logic        rej60;
	logic [2:0]  smooth;
	logic [1:0]  range;
	logic        freeze;
	logic        sleep;
	assign rej60  = ctrl_r[airm_pkg::CT_TEST] ? ctrl_r[airm_pkg::CT_TREJ60]
	                                          : ctrl_r[airm_pkg::CT_REJ60];     // [RULE_10]
	assign smooth = ctrl_r[airm_pkg::CT_TEST] ? ctrl_r[airm_pkg::CT_TSMOOTH +: 3]
	                                          : ctrl_r[airm_pkg::CT_SMOOTH +: 3]; // [RULE_10]
	assign range  = ctrl_r[airm_pkg::CT_RANGE +: 2];
	assign freeze = ctrl_r[airm_pkg::CT_FREEZE];
	assign sleep  = ctrl_r[airm_pkg::CT_SLEEP];

	// Averaging shift: code 0..6 means 2..128 samples
	logic [2:0] ksh;
	assign ksh = (smooth == 3'h7) ? 3'h7 : smooth + 3'h1;                     // [RULE_08]

	// Scaling of the raw result: x - 3x/128 = x * 32000/32768
	logic signed [17:0] raw3;
	logic signed [17:0] raw3s;
	logic signed [15:0] scaled;
	assign raw3   = 18'(signed'(adc_data)) * 18'sh3;
	assign raw3s  = raw3 >>> 7;
	assign scaled = signed'(adc_data) - raw3s[15:0];                          // [RULE_04]

	// Running average step for the channel just converted
	logic signed [S-1:0] xs;
	logic signed [S-1:0] old_avg;
	logic signed [S-1:0] sum_nxt;
	logic signed [S-1:0] avg_w;
	logic signed [15:0]  avg_nxt;
	assign xs      = S'(scaled);
	assign old_avg = sum_r[adc_chan] >>> ksh;
	assign sum_nxt = restart_r[adc_chan] ? (xs <<< ksh)
	                                     : sum_r[adc_chan] - old_avg + xs;    // [RULE_08] [RULE_15]
	assign avg_w   = sum_nxt >>> ksh;
	assign avg_nxt = avg_w[15:0];

	// Lower limit from the range selection
	logic signed [15:0] lim_lo;
	always_comb begin
		case (airm_pkg::airm_range_e'(range))
			airm_pkg::RNG_BIP:  lim_lo = airm_pkg::LIM_LO_BIP;             // [RULE_09]
			airm_pkg::RNG_UNI0: lim_lo = airm_pkg::LIM_LO_UNI0;
			default:            lim_lo = airm_pkg::LIM_LO_OFS;
		endcase
	end

	// Change detection against last reported value
	logic signed [16:0] diff;
	logic        [16:0] adiff;
	logic               chg;
	assign diff  = 17'(avg_nxt) - 17'(rep_r[adc_chan]);
	assign adiff = diff[16] ? 17'(-diff) : diff;
	assign chg   = adc_valid & (change_detect_delta[adc_chan] != 16'h0)
	             & (adiff > {1'b0, change_detect_delta[adc_chan]});          // [RULE_12]

	// Substitution whenever the live value must not be shown
	logic subst_all;
	assign subst_all = freeze | sleep | fail_in;

	// Configuration and control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r           <= airm_pkg::CTRL_RST;
			cal_r            <= airm_pkg::CAL_RST;
			hold_last_sample <= airm_pkg::SUBST_RST[7:0];
			force_r          <= airm_pkg::SUBST_RST[15:8];
			irqm_r           <= '0;
		end else if (wr && blk == 3'h0) begin
			case (wb_adr_i)
				airm_pkg::OFS_CTRL: begin
					if (wb_sel_i[0]) ctrl_r[7:0]  <= wb_dat_i[7:0];
					if (wb_sel_i[1]) ctrl_r[12:8] <= wb_dat_i[12:8];
				end
				airm_pkg::OFS_IRQM: begin
					if (wb_sel_i[0]) irqm_r[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) irqm_r[8]   <= wb_dat_i[8];
				end
				airm_pkg::OFS_CAL:
					if (wb_sel_i[0]) cal_r <= wb_dat_i[7:0];
				airm_pkg::OFS_SUBST: begin
					if (wb_sel_i[0]) hold_last_sample <= wb_dat_i[7:0];
					if (wb_sel_i[1]) force_r          <= wb_dat_i[15:8];      // [RULE_11]
				end
				default: ;
			endcase
		end
	end

	// Per-channel preset and delta tables
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				preset_substitute_value[i] <= '0;
				change_detect_delta[i]     <= '0;
			end
		end else if (wr && blk == airm_pkg::BLK_PRESET) begin
			if (wb_sel_i[0]) preset_substitute_value[widx][7:0]  <= wb_dat_i[7:0];
			if (wb_sel_i[1]) preset_substitute_value[widx][15:8] <= wb_dat_i[15:8];
		end else if (wr && blk == airm_pkg::BLK_DELTA) begin
			if (wb_sel_i[0]) change_detect_delta[widx][7:0]  <= wb_dat_i[7:0];
			if (wb_sel_i[1]) change_detect_delta[widx][15:8] <= wb_dat_i[15:8];
		end
	end

	// Sample timer, halted in sleep
	logic [airm_pkg::TW-1:0] period;
	assign period = rej60 ? airm_pkg::TW'(T60 - 1) : airm_pkg::TW'(T50 - 1);
	always_ff @(posedge mclk) begin
		if (rst || sleep) begin
			tick_cnt_r <= '0;
			conv_start <= 1'b0;                                              // [RULE_13]
		end else if (tick_cnt_r >= period) begin
			tick_cnt_r <= '0;
			conv_start <= 1'b1;                                              // [RULE_07]
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			conv_start <= 1'b0;
		end
	end

	// Restart request on a change of smoothing or range
	logic [2:0] ksh_d_r;
	logic [1:0] range_d_r;
	always_ff @(posedge mclk) begin
		ksh_d_r   <= ksh;
		range_d_r <= range;
		if (rst || ksh != ksh_d_r || range != range_d_r)
			restart_r <= '1;                                                 // [RULE_15]
		else if (adc_valid)
			restart_r[adc_chan] <= 1'b0;
	end

	// Sample store, average and range classification
	always_ff @(posedge mclk) begin
		if (rst) begin
			below_r <= '0;
			above_r <= '0;
			for (int i = 0; i < N; i++) begin
				sum_r[i]  <= '0;
				live_r[i] <= '0;
				last_r[i] <= '0;
				rep_r[i]  <= '0;
			end
		end else if (adc_valid && !sleep) begin
			sum_r[adc_chan]   <= sum_nxt;
			live_r[adc_chan]  <= avg_nxt;
			below_r[adc_chan] <= avg_nxt < lim_lo;                           // [RULE_01] [RULE_14]
			above_r[adc_chan] <= avg_nxt > airm_pkg::LIM_HI;                 // [RULE_02] [RULE_14]
			if (!subst_all)
				last_r[adc_chan] <= avg_nxt;                                 // [RULE_05]
			if (chg)
				rep_r[adc_chan] <= avg_nxt;                                  // [RULE_12]
		end
	end

	// Indicator outputs per channel
	for (genvar c = 0; c < N; c++) begin : g_led
		always_ff @(posedge mclk) begin
			if (rst) begin
				below_range_flag[c] <= 1'b0;
				above_range_flag[c] <= 1'b0;
			end else begin
				below_range_flag[c] <= below_r[c] | ~cal_r[c];              // [RULE_01] [RULE_03]
				above_range_flag[c] <= above_r[c] | ~cal_r[c];              // [RULE_02] [RULE_03]
			end
		end
	end

	// Module failure light and one-cycle event
	always_ff @(posedge mclk) begin
		if (rst) begin
			fail_d_r <= 1'b0;
			err_led  <= 1'b0;
			fail_evt <= 1'b0;
		end else begin
			fail_d_r <= fail_in;
			err_led  <= fail_in;                                             // [RULE_06]
			fail_evt <= fail_in & ~fail_d_r;                                 // [RULE_06]
		end
	end

	// Status bit of the failure event
	localparam int IRQ_B  = airm_pkg::IRQ_FAIL;

	// Sticky interrupt status, set wins over write-one clear
	logic [8:0] irq_set;
	logic [8:0] irq_clr;
	always_comb begin
		irq_set           = '0;
		irq_set[IRQ_B]    = fail_in & ~fail_d_r;
		if (chg && !sleep)
			irq_set[adc_chan] = 1'b1;
		irq_clr = '0;
		if (wr && wb_adr_i == airm_pkg::OFS_IRQS) begin
			if (wb_sel_i[0]) irq_clr[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1]) irq_clr[8]   = wb_dat_i[8];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irqs_r <= '0;
			irq    <= 1'b0;
		end else begin
			irqs_r <= (irqs_r & ~irq_clr) | irq_set;                         // [RULE_12] [RULE_06]
			irq    <= |(irqs_r & irqm_r);
		end
	end

	// Value presented to the application for a channel
	function automatic logic [15:0] shown(input logic [2:0] ch);
		logic use_pre;
		use_pre = sleep | force_r[ch]
		        | (subst_all & ~hold_last_sample[ch]);                       // [RULE_11] [RULE_13]
		if (use_pre)
			shown = preset_substitute_value[ch];
		else if (subst_all)
			shown = last_r[ch];                                              // [RULE_05]
		else
			shown = live_r[ch];
	endfunction : shown

	// Presented value of the addressed channel
	logic [15:0] shown_v;
	always_comb begin
		shown_v = shown(widx);
	end

	// Read data mux, unmapped reads return zero
	logic [31:0] rd;
	always_comb begin
		rd = '0;
		case (blk)
			3'h0: begin
				case (wb_adr_i)
					airm_pkg::OFS_CTRL:  rd = {19'h0, ctrl_r};
					airm_pkg::OFS_STAT:  rd = {30'h0, sleep, fail_in};        // [RULE_06]
					airm_pkg::OFS_IRQS:  rd = {23'h0, irqs_r};
					airm_pkg::OFS_IRQM:  rd = {23'h0, irqm_r};
					airm_pkg::OFS_CAL:   rd = {24'h0, cal_r};
					airm_pkg::OFS_SUBST: rd = {16'h0, force_r, hold_last_sample};
					airm_pkg::OFS_FLAGS: rd = {16'h0, above_range_flag, below_range_flag};
					default:             rd = '0;
				endcase
			end
			airm_pkg::BLK_VALUE:  rd = {{16{shown_v[15]}}, shown_v};
			airm_pkg::BLK_PRESET: rd = {{16{preset_substitute_value[widx][15]}},
			                            preset_substitute_value[widx]};
			airm_pkg::BLK_DELTA:  rd = {16'h0, change_detect_delta[widx]};
			default:              rd = '0;
		endcase
	end

	// Wishbone answer, one wait state
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= req;
			dat_r <= rd;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
endmodule : airm_top

//--- test/airm_chk_sva.sv
// Purpose: Port-level checks for the range monitor
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached to every monitor instance by bind
`timescale 1ns/1ps
module airm_chk #(
	parameter int T50 = 20,
	parameter int T60 = 16
) (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       adc_valid,
	input wire logic       fail_in,
	input wire logic       conv_start,
	input wire logic [7:0] below_range_flag,
	input wire logic [7:0] above_range_flag,
	input wire logic       err_led,
	input wire logic       fail_evt
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	int gap_r;
	// Cycles since the last sample request
	always_ff @(posedge mclk) begin
		if (rst || conv_start)
			gap_r <= 0;
		else if (gap_r < 100000)
			gap_r <= gap_r + 1;
	end
	chk_cs_pulse: assert property (conv_start |=> !conv_start)
		else $error("sample request longer than one cycle");
	chk_cs_gap: assert property (conv_start |-> gap_r >= T60 - 1)
		else $error("sample requests too close");
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_led_follow: assert property (!$past(rst) |-> err_led == $past(fail_in))
		else $error("error light does not follow failure");
	chk_fail_evt: assert property ($rose(fail_in) |=> fail_evt)
		else $error("failure event missing");
	chk_evt_once: assert property (fail_evt |=> !fail_evt)
		else $error("failure event longer than one cycle");
	chk_flag_cause: assert property ($changed(below_range_flag) || $changed(above_range_flag) |->
		$past(adc_valid) || $past(adc_valid, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
		else $error("flags changed without sample or write");
	cov_fail: cover property (fail_evt);
	cov_sample: cover property (conv_start);
	cov_uncal: cover property (below_range_flag[0] && above_range_flag[0]);
endmodule : airm_chk
bind airm_top airm_chk #(.T50(T50), .T60(T60)) u_chk (
	.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .adc_valid, .fail_in,
	.conv_start, .below_range_flag, .above_range_flag, .err_led, .fail_evt
);

//--- test/airm_adc_model.sv
// Purpose: Converter stand-in answering sample requests
// Assumes: Eight results in channel order per request
// Notes:   Data lines toggle while no result is offered
`timescale 1ns/1ps
module airm_adc_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        conv_start,
	output logic             adc_valid,
	output logic      [2:0]  adc_chan,
	output logic      [15:0] adc_data
);
	logic [15:0] raw [8];
	int          dly = 0;
	int          cnt;
	// Cycles since the last request, parked at 99
	always_ff @(posedge mclk) begin
		if (rst)
			cnt <= 99;
		else if (conv_start)
			cnt <= 0;
		else if (cnt < 99)
			cnt <= cnt + 1;
	end
	// One result a cycle once the chosen delay ran out
	always_ff @(posedge mclk) begin
		adc_valid <= !rst && cnt >= dly && cnt < dly + 8;
		adc_chan  <= 3'(cnt - dly);
		adc_data  <= (cnt >= dly && cnt < dly + 8) ? raw[cnt - dly] : ~adc_data;
	end
endmodule : airm_adc_model

//--- test/tb.sv
// Purpose: Self-checking bench for the range monitor
// Assumes: Sample periods shortened to 20 and 16 cycles
// Notes:   Converter model answers every sample request
`timescale 1ns/1ps
module tb;
	localparam int          T50 = 20;
	localparam int          T60 = 16;
	localparam int          RAW [8] = '{-32768, -1000, -300, 0, 6000, 6600, 20000, 32767};
	localparam int          LO [4] = '{-32256, 6144, -256, 6144};
	localparam logic [31:0] CFG [4] = '{32'h000, 32'h001, 32'h300, 32'h000};
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic        fail_in = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic [31:0] q;
	logic        wb_ack_o, adc_valid, conv_start, err_led, fail_evt, irq;
	logic [2:0]  adc_chan;
	logic [15:0] adc_data;
	logic [7:0]  below_range_flag, above_range_flag;
	int          mismatches = 0;
	int          checks = 0;
	// Clock
	always #20 mclk = ~mclk;
	airm_top #(.T50(T50), .T60(T60)) DUT (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .adc_valid, .adc_chan, .adc_data, .fail_in,
		.conv_start, .below_range_flag, .above_range_flag, .err_led, .fail_evt, .irq);
	airm_adc_model adc (.mclk, .rst, .conv_start, .adc_valid, .adc_chan, .adc_data);
	task automatic complete_run();
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'h3;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
		if (n >= 50) begin
			mismatches++;
			complete_run();
		end
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, q, exp);
	endtask : rd
	// Wait for a sample request, counting cycles
	task automatic wcs(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (conv_start !== 1'b1 && n < 100);
		if (n >= 100) begin
			mismatches++;
			complete_run();
		end
	endtask : wcs
	task automatic smp();
		int n;
		wcs(n);
		repeat (16) @(posedge mclk);
	endtask : smp
	function automatic int sc(input int x);
		return x - ((3 * x) >>> 7);
	endfunction : sc
	task automatic t_reset();
		rd(8'h00, 32'h8, "ctrl");
		rd(8'h10, 32'hff, "cal");
		rd(8'h14, 32'hff, "subst");
		rd(8'h0c, 32'h0, "mask");
		bus(1'b1, 8'h3c, 32'hffffffff);
		rd(8'h3c, 32'h0, "unmapped");
	endtask : t_reset
	task automatic t_range();
		logic [7:0] b;
		logic [7:0] a;
		int         v;
		for (int r = 0; r < 4; r++) begin
			bus(1'b1, 8'h00, 32'(r << 4));
			smp();
			for (int c = 0; c < 8; c++) begin
				v = sc(RAW[c]);
				b[c] = v < LO[r];
				a[c] = v > 32256;
				if (r == 0)
					rd(8'(8'h40 + 4 * c), 32'(v), "value");
			end
			chk("below", below_range_flag, b);
			chk("above", above_range_flag, a);
			rd(8'h18, {16'h0, a, b}, "flags");
		end
	endtask : t_range
	task automatic t_cal();
		bus(1'b1, 8'h10, 32'hfe);
		smp();
		chk("uncal", {above_range_flag[0], below_range_flag[0]}, 2'b11);
		bus(1'b1, 8'h10, 32'hff);
	endtask : t_cal
	task automatic t_subst();
		int n;
		adc.dly <= 4;
		bus(1'b1, 8'h68, 32'hf234);
		bus(1'b1, 8'h14, 32'h04ff);
		smp();
		rd(8'h48, 32'hfffff234, "force");
		bus(1'b1, 8'h14, 32'h00ff);
		bus(1'b1, 8'h98, 32'h64);
		smp();
		bus(1'b1, 8'h08, 32'h1ff);
		bus(1'b1, 8'h00, 32'h40);
		adc.raw[6] <= 16'sd1000;
		smp();
		rd(8'h58, 32'(sc(20000)), "frozen");
		bus(1'b1, 8'h00, 32'h02);
		smp();
		rd(8'h58, 32'(sc(1000)), "live");
		rd(8'h08, 32'h40, "change");
		wcs(n);
		adc.raw[6] <= 16'sd5000;
		repeat (16) @(posedge mclk);
		rd(8'h58, 32'((3 * sc(1000) + sc(5000)) >>> 2), "average");
		bus(1'b1, 8'h98, 32'h0);
	endtask : t_subst
	task automatic t_fail();
		fail_in <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("led", err_led, 1'b1);
		chk("irq", irq, 1'b0);
		rd(8'h04, 32'h1, "stat");
		bus(1'b1, 8'h0c, 32'h100);
		repeat (2) @(posedge mclk);
		chk("irq", irq, 1'b1);
		fail_in <= 1'b0;
		bus(1'b1, 8'h08, 32'h1ff);
		repeat (2) @(posedge mclk);
		chk("irq", irq, 1'b0);
		rd(8'h08, 32'h0, "status");
	endtask : t_fail
	task automatic t_rate();
		int n;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 8'h00, CFG[i]);
			wcs(n);
			wcs(n);
			chk("period", 32'(n), 32'(i % 3 ? T60 : T50));
		end
	endtask : t_rate
	task automatic t_sleep();
		int n;
		bus(1'b1, 8'h00, 32'h80);
		rd(8'h04, 32'h2, "stat");
		n = 0;
		repeat (2 * T50) begin
			@(posedge mclk);
			n += (conv_start !== 1'b0);
		end
		chk("requests", 32'(n), 32'h0);
		rd(8'h48, 32'hfffff234, "sleep value");
	endtask : t_sleep
	// Main sequence
	initial begin
		for (int i = 0; i < 8; i++)
			adc.raw[i] = 16'(RAW[i]);
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_range();
		t_cal();
		t_subst();
		t_fail();
		t_rate();
		t_sleep();
		complete_run();
	end
endmodule : tb
